// File: hw/pbd_decoder.sv
`timescale 1ns/1ps
// Summary of operation
// - Addresses in the 4 MB region at FF800000 select flash, 32-bit port.
// - Flash size is programmable, resetting to four megabytes.
// - The 3 MB above flash is undecoded; local timer ends it with error.
// - Reserved local windows never acknowledge; processor timer ends them.
// - Local control bank at FFF40000, global bank at FFF40100, 256 B each.
// - Local control bank takes only 32-bit writes; narrower ones error.
// - Global bank writes of 8/16/32 and all such reads complete normally.
// - Peripheral controller bank in a 4 KB window at FFF42000.
// - Serial controller window at FFF45000 takes 16 or 8-bit only.
// - SCSI controller window at FFF47000 takes 32 or 8-bit accesses.
// - Boot ROM sits in a 256 KB window at FFF80000.
// - Battery RAM and clock in a 64 KB window at FFFC0000.
// - Top 64 KB at FFFF0000 goes to backplane A16 space.
// - Boot ROM also appears at zero after reset until overlay bit cleared.
// - Abort pushbutton drives the non-maskable interrupt.
// - Processor timer counts from bus busy; no termination gives error.
// - Local timeout selects 8, 64 or 256 us, or infinite.
module pbd_decoder #(
	parameter logic [15:0] LP64_CYC  = 16'(pbd_pkg::LP_64_US
		* pbd_pkg::CLK_MHZ),
	parameter logic [15:0] LP256_CYC = 16'(pbd_pkg::LP_256_US
		* pbd_pkg::CLK_MHZ)
) (
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               ce,
	input  wire logic               data_bus_busy_n,
	input  wire pbd_pkg::pbd_req_t  req,
	input  wire pbd_pkg::pbd_term_t term,
	input  wire logic [31:0]        dram_top,
	input  wire logic               flash_size_wr,
	input  wire pbd_pkg::pbd_fsz_t  flash_size_val,
	input  wire logic               proc_to_en,
	input  wire pbd_pkg::pbd_lpsel_t lp_to_sel,
	input  wire logic               abort_n,
	output pbd_pkg::pbd_sel_t       sel_r,
	output logic                    transfer_error_ack_r,
	output logic                    boot_rom_overlay_bit_r,
	output pbd_pkg::pbd_fsz_t       flash_size_r,
	output logic                    nmi_r
);
	localparam logic [15:0] LP8_CYC  = 16'(pbd_pkg::LP_8_US
		* pbd_pkg::CLK_MHZ);
	localparam logic [15:0] PROC_CYC = 16'(pbd_pkg::PROC_TO_US
		* pbd_pkg::CLK_MHZ);
	localparam logic [15:0] CNT_ONE  = 16'h0001;
	localparam logic [15:0] CNT_ZERO = 16'h0000;

	// ****************************************************
	// Decode helpers
	// ****************************************************
	function automatic logic in_win(input logic [31:0] a,
		input logic [31:0] base, input logic [31:0] mask);
		in_win = ((a ^ base) & mask) == 32'h00000000;
	endfunction
	function automatic logic [31:0] flash_bytes(input pbd_pkg::pbd_fsz_t c);
		case (c)
			pbd_pkg::FSZ_C1: flash_bytes = pbd_pkg::FSZ_1MB;
			pbd_pkg::FSZ_C2: flash_bytes = pbd_pkg::FSZ_2MB;
			default:         flash_bytes = pbd_pkg::FSZ_4MB;
		endcase
	endfunction
	function automatic pbd_pkg::pbd_region_t decode(input logic [31:0] a,
		input logic ovl, input logic [31:0] top, input pbd_pkg::pbd_fsz_t fs);
		decode = pbd_pkg::RG_NONE;
		if (ovl && in_win(a, pbd_pkg::ZERO_BASE, pbd_pkg::WIN_256K))
			decode = pbd_pkg::RG_BOOT;
		else if (a < top)
			decode = pbd_pkg::RG_DRAM;
		else if (a < pbd_pkg::VME_LO_END)
			decode = pbd_pkg::RG_VME;
		else if (in_win(a, pbd_pkg::FLASH_BASE, pbd_pkg::FLASH_MASK)) begin
			if ((a & ~pbd_pkg::FLASH_MASK) < flash_bytes(fs))
				decode = pbd_pkg::RG_FLASH;
		end else if (in_win(a, pbd_pkg::SWITCH_BASE, pbd_pkg::WIN_4K))
			decode = pbd_pkg::RG_SWITCH;
		else if (in_win(a, pbd_pkg::MEMCFG_BASE, pbd_pkg::WIN_4K))
			decode = pbd_pkg::RG_MEMCFG;
		else if (in_win(a, pbd_pkg::LCTL_BASE, pbd_pkg::WIN_256))
			decode = pbd_pkg::RG_LCTL;
		else if (in_win(a, pbd_pkg::GCTL_BASE, pbd_pkg::WIN_256))
			decode = pbd_pkg::RG_GCTL;
		else if (in_win(a, pbd_pkg::PERIPH_BASE, pbd_pkg::WIN_4K))
			decode = pbd_pkg::RG_PERIPH;
		else if (in_win(a, pbd_pkg::SERIAL_BASE, pbd_pkg::WIN_4K))
			decode = pbd_pkg::RG_SERIAL;
		else if (in_win(a, pbd_pkg::LAN_BASE, pbd_pkg::WIN_4K))
			decode = pbd_pkg::RG_LAN;
		else if (in_win(a, pbd_pkg::SCSI_BASE, pbd_pkg::WIN_4K))
			decode = pbd_pkg::RG_SCSI;
		else if (in_win(a, pbd_pkg::BOOT_BASE, pbd_pkg::WIN_256K))
			decode = pbd_pkg::RG_BOOT;
		else if (in_win(a, pbd_pkg::BATTERY_BACKED_RAM_BASE, pbd_pkg::WIN_64K))
			decode = pbd_pkg::RG_BATTERY_BACKED_RAM;
		else if (in_win(a, pbd_pkg::A16_BASE, pbd_pkg::WIN_64K))
			decode = pbd_pkg::RG_A16;
	endfunction
	// Widths refused by the target window end at once with an error
	function automatic logic width_bad(input pbd_pkg::pbd_region_t rg,
		input pbd_pkg::pbd_size_t sz, input logic wr);
		logic d64_ok;
		d64_ok = (rg == pbd_pkg::RG_SWITCH) || (rg == pbd_pkg::RG_DRAM)
			|| (rg == pbd_pkg::RG_NONE);
		width_bad = (sz == pbd_pkg::SZ64 && !d64_ok)
			|| (rg == pbd_pkg::RG_LCTL && wr && sz != pbd_pkg::SZ32)
			|| (rg == pbd_pkg::RG_SERIAL && sz == pbd_pkg::SZ32)
			|| (rg == pbd_pkg::RG_SCSI && sz == pbd_pkg::SZ16);
	endfunction

	// ****************************************************
	// Cycle tracking and timeout
	// ****************************************************
	pbd_pkg::pbd_state_t  st_r;
	pbd_pkg::pbd_state_t  st_nxt;
	pbd_pkg::pbd_sel_t    sel_nxt;
	logic                 tea_nxt;
	logic [15:0]          cnt_r;
	logic [15:0]          cnt_nxt;
	logic [15:0]          lim_r;
	logic [15:0]          lim_nxt;
	logic                 tmr_en_r;
	logic                 tmr_en_nxt;
	pbd_pkg::pbd_region_t dec_rg;
	pbd_pkg::pbd_tmr_t    dec_tmr;
	logic                 start;
	logic                 bad;
	logic                 ended;
	assign start = (st_r == pbd_pkg::ST_IDLE) && !data_bus_busy_n;
	assign ended = term.ack || term.err || term.retry || data_bus_busy_n;
	always_comb begin
		dec_rg = decode(req.addr, boot_rom_overlay_bit_r, dram_top,
			flash_size_r);
		bad = width_bad(dec_rg, req.size, req.write);
		case (dec_rg)
			pbd_pkg::RG_DRAM: dec_tmr = pbd_pkg::TMR_PROC;
			pbd_pkg::RG_VME,
			pbd_pkg::RG_A16:  dec_tmr = pbd_pkg::TMR_NONE;
			pbd_pkg::RG_NONE: begin
				// Reserved local windows: processor timer; rest: local timer
				if (req.addr >= pbd_pkg::LOCAL_BASE
					&& req.addr < pbd_pkg::LOCAL_END)
					dec_tmr = pbd_pkg::TMR_PROC;
				else
					dec_tmr = pbd_pkg::TMR_LP;
			end
			default:          dec_tmr = pbd_pkg::TMR_LP;
		endcase
	end
	always_comb begin
		st_nxt = st_r;
		sel_nxt = sel_r;
		tea_nxt = 1'b0;
		cnt_nxt = cnt_r;
		lim_nxt = lim_r;
		tmr_en_nxt = tmr_en_r;
		case (st_r)
			pbd_pkg::ST_IDLE: begin
				if (start) begin
					sel_nxt.region = dec_rg;
					cnt_nxt = CNT_ZERO;
					if (dec_tmr == pbd_pkg::TMR_PROC) begin
						tmr_en_nxt = proc_to_en;
						lim_nxt = PROC_CYC;
					end else if (dec_tmr == pbd_pkg::TMR_LP) begin
						tmr_en_nxt = lp_to_sel != pbd_pkg::LP_INF;
						case (lp_to_sel)
							pbd_pkg::LP_8:   lim_nxt = LP8_CYC;
							pbd_pkg::LP_64:  lim_nxt = LP64_CYC;
							default:         lim_nxt = LP256_CYC;
						endcase
					end else begin
						tmr_en_nxt = 1'b0;
					end
					if (bad) begin
						st_nxt = pbd_pkg::ST_ERR;
						tea_nxt = 1'b1;
					end else begin
						st_nxt = pbd_pkg::ST_BUSY;
						sel_nxt.active = dec_rg != pbd_pkg::RG_NONE;
					end
				end
			end
			pbd_pkg::ST_BUSY: begin
				if (ended) begin
					st_nxt = pbd_pkg::ST_IDLE;
					sel_nxt.active = 1'b0;
				end else if (tmr_en_r && cnt_r >= lim_r) begin
					st_nxt = pbd_pkg::ST_ERR;
					tea_nxt = 1'b1;
					sel_nxt.active = 1'b0;
				end else begin
					cnt_nxt = cnt_r + CNT_ONE;
				end
			end
			pbd_pkg::ST_ERR: begin
				st_nxt = pbd_pkg::ST_IDLE;
			end
			default: begin
				st_nxt = pbd_pkg::ST_IDLE;
				sel_nxt.active = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			st_r <= pbd_pkg::ST_IDLE;
			sel_r <= '{active: 1'b0, region: pbd_pkg::RG_NONE};
			transfer_error_ack_r <= 1'b0;
			cnt_r <= CNT_ZERO;
			lim_r <= CNT_ZERO;
			tmr_en_r <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
			sel_r <= sel_nxt;
			transfer_error_ack_r <= tea_nxt;
			cnt_r <= cnt_nxt;
			lim_r <= lim_nxt;
			tmr_en_r <= tmr_en_nxt;
		end
	end
	default clocking dflt_cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	sequence start_s;
		ce && start;
	endsequence
	local_width_a: assert property (
		start_s ##0 (dec_rg == pbd_pkg::RG_LCTL && req.write
		&& req.size != pbd_pkg::SZ32) |=> transfer_error_ack_r)
		else $error("narrow local control write not refused");
	global_write_a: assert property (
		start_s ##0 (dec_rg == pbd_pkg::RG_GCTL
		&& req.size != pbd_pkg::SZ64)
		|=> !transfer_error_ack_r && sel_r.active)
		else $error("global control access refused");
	serial_width_a: assert property (
		start_s ##0 (dec_rg == pbd_pkg::RG_SERIAL
		&& req.size == pbd_pkg::SZ32) |=> transfer_error_ack_r)
		else $error("32-bit serial access accepted");
	reserved_local_a: assert property (
		start_s ##0 (req.addr == 32'hFFF02000) |=> !sel_r.active
		&& sel_r.region == pbd_pkg::RG_NONE && tmr_en_r == $past(proc_to_en))
		else $error("reserved local window selected a device");
	flash_route_a: assert property (
		start_s ##0 (req.addr[31:22] == pbd_pkg::FLASH_BASE[31:22]
		&& flash_size_r == pbd_pkg::FSZ_C4 && !boot_rom_overlay_bit_r)
		|=> sel_r.region == pbd_pkg::RG_FLASH)
		else $error("flash address not routed to flash");
	a16_route_a: assert property (
		start_s ##0 (req.addr[31:16] == pbd_pkg::A16_BASE[31:16])
		|=> sel_r.region == pbd_pkg::RG_A16 && !tmr_en_r)
		else $error("top 64 KB not routed to A16 space");
	timeout_fire_a: assert property (
		(ce && st_r == pbd_pkg::ST_BUSY && tmr_en_r && cnt_r >= lim_r
		&& !ended) |=> transfer_error_ack_r ##0 st_r == pbd_pkg::ST_ERR)
		else $error("timeout expired without error acknowledge");
	term_wins_a: assert property (
		(ce && st_r == pbd_pkg::ST_BUSY && term.ack)
		|=> !transfer_error_ack_r && st_r == pbd_pkg::ST_IDLE)
		else $error("terminated cycle still got an error");
	tea_pulse_a: assert property (
		(ce && transfer_error_ack_r) |=> !transfer_error_ack_r)
		else $error("error acknowledge held over one cycle");

	// ****************************************************
	// Overlay bit and flash size
	// ****************************************************
	logic              ovl_nxt;
	pbd_pkg::pbd_fsz_t fsz_nxt;
	logic              ovl_wr;
	// Snooped write to the peripheral controller's first register
	// A refused write must not move the overlay
	assign ovl_wr = start && req.write && req.addr == pbd_pkg::PERIPH_BASE
		&& req.size != pbd_pkg::SZ8 && !bad;
	always_comb begin
		ovl_nxt = boot_rom_overlay_bit_r;
		fsz_nxt = flash_size_r;
		if (ovl_wr)
			ovl_nxt = req.wd15;
		if (flash_size_wr)
			fsz_nxt = flash_size_val;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			boot_rom_overlay_bit_r <= 1'b1;
			flash_size_r <= pbd_pkg::FSZ_RESET;
		end else if (ce) begin
			boot_rom_overlay_bit_r <= ovl_nxt;
			flash_size_r <= fsz_nxt;
		end
	end

	overlay_reset_a: assert property (
		$fell(rst) |-> boot_rom_overlay_bit_r
		&& flash_size_r == pbd_pkg::FSZ_C4)
		else $error("overlay or flash size wrong after reset");
	overlay_map_a: assert property (
		start_s ##0 (boot_rom_overlay_bit_r && req.addr[31:18] == 14'h0000)
		|=> sel_r.region == pbd_pkg::RG_BOOT)
		else $error("boot ROM missing at zero under overlay");

	// ****************************************************
	// Abort pushbutton
	// ****************************************************
	// Three stages: the third exists only to confirm the second
	logic abort_s1_r;
	logic abort_s2_r;
	logic abort_s3_r;
	logic nmi_nxt;
	always_comb begin
		nmi_nxt = nmi_r;
		if (abort_s2_r == abort_s3_r)
			nmi_nxt = !abort_s3_r;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			abort_s1_r <= 1'b1;
			abort_s2_r <= 1'b1;
			abort_s3_r <= 1'b1;
			nmi_r <= 1'b0;
		end else if (ce) begin
			abort_s1_r <= abort_n;
			abort_s2_r <= abort_s1_r;
			abort_s3_r <= abort_s2_r;
			nmi_r <= nmi_nxt;
		end
	end

	abort_nmi_a: assert property (
		(ce && !abort_s2_r && !abort_s3_r) |=> nmi_r)
		else $error("settled abort did not raise the interrupt");
endmodule

// File: hw/pbd_pkg.sv
package pbd_pkg;
	// ****************************************************
	// Timing
	// ****************************************************
	localparam int CLK_MHZ      = 125;
	localparam int LP_8_US      = 8;
	localparam int LP_64_US     = 64;
	localparam int LP_256_US    = 256;
	localparam int PROC_TO_US   = 16;
	localparam int CNT_W        = 16;
	// ****************************************************
	// Address map
	// ****************************************************
	localparam logic [31:0] VME_LO_END   = 32'hFF800000;
	localparam logic [31:0] FLASH_BASE   = 32'hFF800000;
	localparam logic [31:0] FLASH_MASK   = 32'hFFC00000;
	localparam logic [31:0] FGAP_BASE    = 32'hFFC00000;
	localparam logic [31:0] FGAP_END     = 32'hFFF00000;
	localparam logic [31:0] LOCAL_BASE   = 32'hFFF00000;
	localparam logic [31:0] LOCAL_END    = 32'hFFFF0000;
	localparam logic [31:0] WIN_4K       = 32'hFFFFF000;
	localparam logic [31:0] WIN_256      = 32'hFFFFFF00;
	localparam logic [31:0] WIN_64K      = 32'hFFFF0000;
	localparam logic [31:0] WIN_256K     = 32'hFFFC0000;
	localparam logic [31:0] SWITCH_BASE  = 32'hFFF00000;
	localparam logic [31:0] MEMCFG_BASE  = 32'hFFF01000;
	localparam logic [31:0] LCTL_BASE    = 32'hFFF40000;
	localparam logic [31:0] GCTL_BASE    = 32'hFFF40100;
	localparam logic [31:0] PERIPH_BASE  = 32'hFFF42000;
	localparam logic [31:0] SERIAL_BASE  = 32'hFFF45000;
	localparam logic [31:0] LAN_BASE     = 32'hFFF46000;
	localparam logic [31:0] SCSI_BASE    = 32'hFFF47000;
	localparam logic [31:0] BOOT_BASE    = 32'hFFF80000;
	localparam logic [31:0] BATTERY_BACKED_RAM_BASE   = 32'hFFFC0000;
	localparam logic [31:0] A16_BASE     = 32'hFFFF0000;
	localparam logic [31:0] ZERO_BASE    = 32'h00000000;
	localparam logic [31:0] FSZ_1MB      = 32'h00100000;
	localparam logic [31:0] FSZ_2MB      = 32'h00200000;
	localparam logic [31:0] FSZ_4MB      = 32'h00400000;
	// ****************************************************
	// Types
	// ****************************************************
	typedef enum logic [1:0] {
		FSZ_C1 = 2'h0, FSZ_C2 = 2'h1, FSZ_C4 = 2'h2
	} pbd_fsz_t;
	localparam pbd_fsz_t FSZ_RESET = FSZ_C4;
	typedef enum logic [1:0] {
		SZ8 = 2'h0, SZ16 = 2'h1, SZ32 = 2'h2, SZ64 = 2'h3
	} pbd_size_t;
	typedef enum logic [1:0] {
		LP_8 = 2'h0, LP_64 = 2'h1, LP_256 = 2'h2, LP_INF = 2'h3
	} pbd_lpsel_t;
	typedef enum logic [1:0] {
		TMR_NONE = 2'h0, TMR_PROC = 2'h1, TMR_LP = 2'h2
	} pbd_tmr_t;
	typedef enum logic [3:0] {
		RG_NONE = 4'h0, RG_DRAM = 4'h1, RG_VME = 4'h2, RG_FLASH = 4'h3,
		RG_SWITCH = 4'h4, RG_MEMCFG = 4'h5, RG_LCTL = 4'h6,
		RG_GCTL = 4'h7, RG_PERIPH = 4'h8, RG_SERIAL = 4'h9,
		RG_LAN = 4'hA, RG_SCSI = 4'hB, RG_BOOT = 4'hC,
		RG_BATTERY_BACKED_RAM = 4'hD, RG_A16 = 4'hE
	} pbd_region_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0, ST_BUSY = 2'h1, ST_ERR = 2'h3
	} pbd_state_t;
	typedef struct packed {
		logic [31:0] addr;
		pbd_size_t   size;
		logic        write;
		logic        wd15;
	} pbd_req_t;
	typedef struct packed {
		logic ack;
		logic err;
		logic retry;
	} pbd_term_t;
	typedef struct packed {
		logic        active;
		pbd_region_t region;
	} pbd_sel_t;
endpackage

// File: verification/pbd_target_model.sv
`timescale 1ns/1ps
// ********
// Target devices behind the decoder
// ********
module pbd_target_model (
	input  wire logic              core_clk,
	input  wire logic              rst,
	input  wire pbd_pkg::pbd_sel_t sel,
	input  wire logic [1:0]        mode,
	input  wire logic [3:0]        dly,
	output pbd_pkg::pbd_term_t     term
);
	logic [3:0] cnt;
	logic       done;
	logic       fire;

	// Mode 3 never answers, so the bus timers must end the cycle
	assign fire = !rst && sel.active && !done && cnt == dly && mode != 2'h3;

	always @(negedge core_clk) begin
		term.ack <= fire && mode == 2'h0;
		term.err <= fire && mode == 2'h1;
		term.retry <= fire && mode == 2'h2;
		if (rst || !sel.active) begin
			cnt <= 4'h0;
			done <= 1'h0;
		end else if (fire) begin
			done <= 1'h1;
		end else if (!done) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule

// File: verification/tb.sv
`timescale 1ns/1ps
// ********
// Decoder testbench
// ********
module tb;
	logic                core_clk;
	logic                rst;
	logic                busy_n;
	logic                fsw;
	logic                pto;
	logic                ab_n;
	logic                ce;
	logic [1:0]          mode;
	logic [3:0]          dly;
	pbd_pkg::pbd_req_t   req;
	pbd_pkg::pbd_term_t  term;
	pbd_pkg::pbd_fsz_t   fsv;
	pbd_pkg::pbd_fsz_t   fsz;
	pbd_pkg::pbd_lpsel_t lps;
	pbd_pkg::pbd_sel_t   sel;
	logic                transfer_error_ack;
	logic                ovl;
	logic                nmi;
	int                  n_fail;
	int                  n_checks;

	// Short local timeouts keep the run brief
	pbd_decoder #(.LP64_CYC(16'h0014), .LP256_CYC(16'h0028)) i_pbd_decoder (
		.core_clk(core_clk), .rst(rst), .ce(ce),
		.data_bus_busy_n(busy_n), .req(req), .term(term),
		.dram_top(32'h01000000), .flash_size_wr(fsw),
		.flash_size_val(fsv), .proc_to_en(pto), .lp_to_sel(lps),
		.abort_n(ab_n), .sel_r(sel), .transfer_error_ack_r(transfer_error_ack),
		.boot_rom_overlay_bit_r(ovl), .flash_size_r(fsz), .nmi_r(nmi));

	pbd_target_model i_pbd_target_model (.core_clk(core_clk), .rst(rst),
		.sel(sel), .mode(mode), .dly(dly), .term(term));

	initial begin
		core_clk = 1'h0;
		forever #4 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic start(input logic [31:0] a, input pbd_pkg::pbd_size_t sz,
		input logic wr, input logic d15);
		@(negedge core_clk);
		req = '{a, sz, wr, d15};
		busy_n = 1'h0;
		@(negedge core_clk);
	endtask

	task automatic access(input logic [31:0] a, input pbd_pkg::pbd_size_t sz,
		input logic wr, input logic d15, input pbd_pkg::pbd_region_t rg);
		int i;
		start(a, sz, wr, d15);
		chk("active", 32'h1, sel.active);
		chk("region", rg, sel.region);
		for (i = 0; i < 20 && sel.active === 1'h1; i++)
			@(negedge core_clk);
		if (sel.active !== 1'h0) begin
			n_fail++;
			complete_run();
		end
		busy_n = 1'h1;
	endtask

	task automatic refuse(input logic [31:0] a, input pbd_pkg::pbd_size_t sz,
		input logic wr);
		start(a, sz, wr, 1'h0);
		chk("tea", 32'h1, transfer_error_ack);
		chk("active", 32'h0, sel.active);
		busy_n = 1'h1;
		@(negedge core_clk);
		chk("tea drop", 32'h0, transfer_error_ack);
	endtask

	// Negative limit means no timer should ever fire
	task automatic timeout(input logic [31:0] a, input int lim, input logic act);
		start(a, pbd_pkg::SZ32, 1'h0, 1'h0);
		chk("active", act, sel.active);
		if (lim < 0) begin
			repeat (100) @(negedge core_clk);
			chk("tea idle", 32'h0, transfer_error_ack);
		end else begin
			repeat (lim) @(negedge core_clk);
			chk("tea early", 32'h0, transfer_error_ack);
			@(negedge core_clk);
			chk("tea", 32'h1, transfer_error_ack);
		end
		busy_n = 1'h1;
		@(negedge core_clk);
		chk("tea drop", 32'h0, transfer_error_ack);
	endtask

	task automatic t_reset;
		chk("sel", 32'h0, sel);
		chk("tea", 32'h0, transfer_error_ack);
		chk("overlay", 32'h1, ovl);
		chk("fsize", pbd_pkg::FSZ_C4, fsz);
		chk("nmi", 32'h0, nmi);
		$display("test reset done");
	endtask

	task automatic t_decode;
		access(32'hFF800000, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_FLASH);
		access(32'hFFBFFFFC, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_FLASH);
		access(32'hFFF00000, pbd_pkg::SZ64, 1, 0, pbd_pkg::RG_SWITCH);
		access(32'hFFF00FFF, pbd_pkg::SZ8, 0, 0, pbd_pkg::RG_SWITCH);
		access(32'hFFF01000, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_MEMCFG);
		access(32'hFFF40000, pbd_pkg::SZ32, 1, 0, pbd_pkg::RG_LCTL);
		access(32'hFFF400FF, pbd_pkg::SZ8, 0, 0, pbd_pkg::RG_LCTL);
		access(32'hFFF40100, pbd_pkg::SZ8, 1, 0, pbd_pkg::RG_GCTL);
		access(32'hFFF401FE, pbd_pkg::SZ16, 1, 0, pbd_pkg::RG_GCTL);
		access(32'hFFF42FFC, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_PERIPH);
		access(32'hFFF45000, pbd_pkg::SZ16, 1, 0, pbd_pkg::RG_SERIAL);
		access(32'hFFF45FFF, pbd_pkg::SZ8, 0, 0, pbd_pkg::RG_SERIAL);
		// Port command as two halfwords, upper one first
		access(32'hFFF46000, pbd_pkg::SZ16, 1, 0, pbd_pkg::RG_LAN);
		access(32'hFFF46002, pbd_pkg::SZ16, 1, 0, pbd_pkg::RG_LAN);
		access(32'hFFF47000, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_SCSI);
		access(32'hFFF47FFF, pbd_pkg::SZ8, 1, 0, pbd_pkg::RG_SCSI);
		access(32'hFFFBFFFC, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_BOOT);
		access(32'hFFFC0000, pbd_pkg::SZ8, 1, 0, pbd_pkg::RG_BATTERY_BACKED_RAM);
		access(32'hFFFF0000, pbd_pkg::SZ16, 0, 0, pbd_pkg::RG_A16);
		access(32'h00000000, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_BOOT);
		mode = 2'h1;
		access(32'hFF800000, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_FLASH);
		mode = 2'h2;
		access(32'hFF800000, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_FLASH);
		mode = 2'h0;
		$display("test decode done");
	endtask

	task automatic t_refuse;
		refuse(32'hFFF40000, pbd_pkg::SZ16, 1'h1);
		refuse(32'hFFF400FC, pbd_pkg::SZ8, 1'h1);
		refuse(32'hFFF45000, pbd_pkg::SZ32, 1'h0);
		refuse(32'hFFF47000, pbd_pkg::SZ16, 1'h0);
		refuse(32'hFFF46000, pbd_pkg::SZ64, 1'h0);
		$display("test refuse done");
	endtask

	task automatic t_overlay;
		access(32'hFFF42000, pbd_pkg::SZ16, 1, 1, pbd_pkg::RG_PERIPH);
		chk("overlay", 32'h1, ovl);
		access(32'hFFF42000, pbd_pkg::SZ16, 1, 0, pbd_pkg::RG_PERIPH);
		chk("overlay", 32'h0, ovl);
		// Overlay now off, so DRAM may be touched
		access(32'h00000000, pbd_pkg::SZ64, 0, 0, pbd_pkg::RG_DRAM);
		access(32'h00FFFFF8, pbd_pkg::SZ64, 1, 0, pbd_pkg::RG_DRAM);
		access(32'h01000000, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_VME);
		$display("test overlay done");
	endtask

	task automatic t_timeout;
		mode = 2'h3;
		pto = 1'h1;
		timeout(32'hFFF02000, 2000, 1'h0);
		timeout(32'hFFF40200, 2000, 1'h0);
		timeout(32'h00000000, 2000, 1'h1);
		pto = 1'h0;
		timeout(32'hFFF02000, -1, 1'h0);
		lps = pbd_pkg::LP_8;
		timeout(32'hFFC00000, 1000, 1'h0);
		lps = pbd_pkg::LP_64;
		timeout(32'hFFEFFFFC, 20, 1'h0);
		lps = pbd_pkg::LP_256;
		timeout(32'hFFD00000, 40, 1'h0);
		lps = pbd_pkg::LP_INF;
		timeout(32'hFFC00000, -1, 1'h0);
		mode = 2'h0;
		$display("test timeout done");
	endtask

	task automatic t_fsize;
		fsv = pbd_pkg::FSZ_C1;
		fsw = 1'h1;
		@(negedge core_clk);
		fsw = 1'h0;
		@(negedge core_clk);
		chk("fsize", pbd_pkg::FSZ_C1, fsz);
		timeout(32'hFF900000, -1, 1'h0);
		fsv = pbd_pkg::FSZ_C2;
		fsw = 1'h1;
		@(negedge core_clk);
		fsw = 1'h0;
		@(negedge core_clk);
		chk("fsize", pbd_pkg::FSZ_C2, fsz);
		access(32'hFF900000, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_FLASH);
		timeout(32'hFFA00000, -1, 1'h0);
		fsv = pbd_pkg::FSZ_C4;
		fsw = 1'h1;
		@(negedge core_clk);
		fsw = 1'h0;
		@(negedge core_clk);
		chk("fsize", pbd_pkg::FSZ_C4, fsz);
		access(32'hFF900000, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_FLASH);
		$display("test flash size done");
	endtask

	task automatic t_abort;
		int i;
		ab_n = 1'h0;
		for (i = 0; i < 8 && nmi !== 1'h1; i++)
			@(negedge core_clk);
		chk("nmi", 32'h1, nmi);
		ab_n = 1'h1;
		for (i = 0; i < 8 && nmi !== 1'h0; i++)
			@(negedge core_clk);
		chk("nmi", 32'h0, nmi);
		$display("test abort done");
	endtask

	// With the enable low a waiting request must not be taken
	task automatic t_freeze;
		ce = 1'h0;
		req = '{32'hFF800000, pbd_pkg::SZ32, 1'h0, 1'h0};
		busy_n = 1'h0;
		repeat (3) @(negedge core_clk);
		chk("frozen active", 32'h0, sel.active);
		chk("frozen tea", 32'h0, transfer_error_ack);
		busy_n = 1'h1;
		@(negedge core_clk);
		ce = 1'h1;
		access(32'hFF800000, pbd_pkg::SZ32, 0, 0, pbd_pkg::RG_FLASH);
		$display("test freeze done");
	endtask

	initial begin
		rst = 1'h1;
		ce = 1'h1;
		busy_n = 1'h1;
		fsw = 1'h0;
		pto = 1'h0;
		ab_n = 1'h1;
		mode = 2'h0;
		dly = 4'h1;
		req = '0;
		fsv = pbd_pkg::FSZ_C4;
		lps = pbd_pkg::LP_INF;
		n_fail = 0;
		n_checks = 0;
		repeat (5) @(negedge core_clk);
		rst = 1'h0;
		t_reset();
		t_decode();
		t_refuse();
		t_overlay();
		t_timeout();
		t_fsize();
		t_abort();
		t_freeze();
		complete_run();
	end
endmodule
